// *** include/dsr_pkg.sv ***
// constants, encodings and types for the self-refresh / partial-array / mode-read block
// assumes one core clock at 125 MHz; all times converted to cycles here
package dsr_pkg;

  // ==========================================================================
  // clock and time conversion
  localparam int CLK_PERIOD_NS = 8;

  // least times round up, longest times round down; only the minimum dwell is held at one cycle or more
  localparam int SR_MIN_DWELL_NS = 15;
  localparam int SR_MIN_DWELL_CYC = ((SR_MIN_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ?
                                    1 : ((SR_MIN_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SR_EXIT_DELAY_NS = 220;
  localparam int SR_EXIT_DELAY_CYC = (SR_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_REFRESH_INTERVAL_NS = 3900;
  localparam int SR_REFRESH_INTERVAL_CYC = SR_REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int SR_FIRST_REFRESH_CYC = 1;
  localparam int POWERDOWN_ENTRY_CYC = 2;
  localparam int STROBE_OUTPUT_DELAY_NS = 5;
  localparam int STROBE_OUTPUT_DELAY_CYC =
    (STROBE_OUTPUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_LATENCY_CYC = 8;
  localparam int MRR_LATENCY_CYC = READ_LATENCY_CYC + STROBE_OUTPUT_DELAY_CYC;
  localparam int MRR_BURST_BEATS = 8;

  // ==========================================================================
  // mode register addresses and values
  localparam logic [7:0] MR_ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] MR_ADDR_SEGMENT_MASK = 8'h11;
  localparam logic [7:0] MR_ADDR_PASR_RESERVED = 8'h12;
  localparam logic [7:0] MR_ADDR_CAL_A = 8'h20;
  localparam logic [7:0] MR_ADDR_CAL_B = 8'h28;
  localparam logic [7:0] CAL_PATTERN_A = 8'h55;
  localparam logic [7:0] CAL_PATTERN_B = 8'hCC;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // ==========================================================================
  // command bus encodings (CA3..CA0 at rising edge)
  localparam logic [2:0] CA_NOP = 3'h7;
  localparam logic [2:0] CA_SELF_REFRESH = 3'h4;
  localparam logic [3:0] CA_MODE_REG_READ = 4'h8;
  localparam logic [3:0] CA_MODE_REG_WRITE = 4'h0;

  typedef enum logic [2:0] {
    DSR_CMD_DESELECT = 3'b000,
    DSR_CMD_NOP = 3'b001,
    DSR_CMD_SELF_REFRESH = 3'b010,
    DSR_CMD_MODE_READ = 3'b011,
    DSR_CMD_MODE_WRITE = 3'b100,
    DSR_CMD_OTHER = 3'b101
  } dsr_cmd_type;

  typedef enum logic [1:0] {
    DSR_ST_IDLE = 2'b00,
    DSR_ST_SR_ENTRY = 2'b01,
    DSR_ST_SR = 2'b10,
    DSR_ST_SR_EXIT = 2'b11
  } dsr_state_type;

endpackage

// *** include/dsr_mrr_if.sv ***
// carrier between the command decoder and the mode-read burst generator
// assumes both ends run on core_clk
`timescale 1ns/1ps
`default_nettype none
interface dsr_mrr_if;
  logic start;
  logic [7:0] regData;
  logic calMode;
  logic [7:0] calPattern;
  logic busy;
  logic [31:0] dq;
  logic dqOe;
  logic [3:0] dqs;
  logic dqsOe;

  modport ctrl (output start, regData, calMode, calPattern,
                input busy, dq, dqOe, dqs, dqsOe);
  modport burst (input start, regData, calMode, calPattern,
                 output busy, dq, dqOe, dqs, dqsOe);
endinterface
`default_nettype wire

// *** src/dsr_mrr_burst.sv ***
// mode-register read burst: latency wait, eight beats, strobes toggling
// assumes start is a one-cycle pulse only accepted while busy is low
`timescale 1ns/1ps
`default_nettype none
module dsr_mrr_burst
  import dsr_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rstN, // synchronised reset, active low
  dsr_mrr_if.burst bus // request and data lanes
);

  localparam logic [4:0] LAT = 5'(MRR_LATENCY_CYC);
  localparam logic [4:0] LAST = 5'(MRR_LATENCY_CYC + MRR_BURST_BEATS);

  logic active_reg;
  logic [4:0] cnt_reg;
  logic [7:0] data_reg;
  logic cal_reg;
  logic [7:0] pat_reg;
  logic [31:0] dq_reg;
  logic dqOe_reg;
  logic [3:0] dqs_reg;
  logic [2:0] beat;

  assign beat = 3'(cnt_reg - LAT);

  // ==========================================================================
  // sequencing
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      active_reg <= 1'b0;
      cnt_reg <= 5'h00;
    end else if (bus.start && !active_reg) begin
      active_reg <= 1'b1;
      cnt_reg <= 5'h01;
    end else if (active_reg) begin
      cnt_reg <= cnt_reg + 5'h01;
      if (cnt_reg == LAST) begin
        active_reg <= 1'b0; // burst never cut short
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      data_reg <= 8'h00;
      cal_reg <= 1'b0;
      pat_reg <= 8'h00;
    end else if (bus.start && !active_reg) begin
      data_reg <= bus.regData;
      cal_reg <= bus.calMode;
      pat_reg <= bus.calPattern;
    end
  end

  // ==========================================================================
  // data and strobe lanes
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      dq_reg <= 32'h0000_0000;
      dqOe_reg <= 1'b0;
      dqs_reg <= 4'h0;
    end else if (active_reg && cnt_reg >= LAT && cnt_reg < LAST) begin
      dqOe_reg <= 1'b1;
      dqs_reg <= {4{~beat[0]}}; // all strobes toggle
      if (cal_reg) begin
        dq_reg <= {32{pat_reg[beat]}};
      end else if (beat == 3'h0) begin
        dq_reg <= {24'h00_0000, data_reg};
      end else begin
        dq_reg <= 32'h0000_0000;
      end
    end else begin
      dqOe_reg <= 1'b0;
      dqs_reg <= 4'h0;
      dq_reg <= 32'h0000_0000;
    end
  end

  assign bus.busy = active_reg;
  assign bus.dq = dq_reg;
  assign bus.dqOe = dqOe_reg;
  assign bus.dqs = dqs_reg;
  assign bus.dqsOe = dqOe_reg;

endmodule
`default_nettype wire

// *** src/dsr_self_refresh_pasr_mrr.sv ***
// device-side self refresh, partial-array masking and mode-register read/write
// assumes command/address pins are synchronous to core_clk (controller clock)
//
// Notes on behaviour
// - self-refresh entry: clock-gate low now, high before, CS low, CA=100.
// - receivers switch off after entry delay; clock-gate low keeps self refresh.
// - in self refresh only clock-gate is heard; internal timer keeps refreshing.
// - first internal all-bank refresh falls inside the minimum dwell; here only on entry from idle, re-entry during exit keeps the running timer.
// - bank mask bit set blocks self refresh of that bank.
// - segment mask bit set blocks that segment in every unmasked bank.
// - writes to the reserved partial-array register change nothing.
// - mode read decoded with CS low, CA=1000; address from fall and rise bits.
// - register value on DQ[7:0] of beat 0, after read latency plus delay.
// - every strobe toggles for the whole mode read burst.
// - mode read burst is eight beats, uninterrupted; only NOPs meanwhile.
`timescale 1ns/1ps
`default_nettype none
module dsr_self_refresh_pasr_mrr
  import dsr_pkg::*;
(
  input wire logic core_clk, // controller clock
  input wire logic reset_n, // asynchronous reset, active low
  input wire logic cke, // clock-gate input
  input wire logic csN, // chip select, active low
  input wire logic [9:0] caRise, // command/address at rising edge
  input wire logic [9:0] caFall, // command/address at falling edge
  output logic [31:0] dqOut, // data lanes out
  output logic dqOe, // data lanes driven
  output logic [3:0] dqsOut, // data strobes out
  output logic dqsOe, // data strobes driven
  output logic receiversOn, // input receivers enabled
  output logic inSelfRefresh, // device in self-refresh entry, self refresh or its exit
  output logic refreshPulse, // internal all-bank refresh event
  output logic [7:0] refreshBankEn, // banks refreshed by that event
  output logic [7:0] refreshSegEn, // segments refreshed by that event
  output logic dwellMet, // minimum dwell elapsed
  output logic exitBusy, // exit delay running
  output logic mrrBusy, // mode read burst in progress
  output logic [7:0] bankMaskOut, // bank mask register
  output logic [7:0] segMaskOut, // segment mask register
  output logic cmdIgnored // command dropped in the previous cycle
);

  // ==========================================================================
  // helpers
  function automatic dsr_cmd_type decodeCmd(input logic cs, input logic [9:0] ca);
    dsr_cmd_type c;
    c = DSR_CMD_OTHER;
    if (cs) begin
      c = DSR_CMD_DESELECT;
    end else if (ca[2:0] == CA_NOP) begin
      c = DSR_CMD_NOP;
    end else if (ca[2:0] == CA_SELF_REFRESH) begin
      c = DSR_CMD_SELF_REFRESH;
    end else if (ca[3:0] == CA_MODE_REG_READ) begin
      c = DSR_CMD_MODE_READ;
    end else if (ca[3:0] == CA_MODE_REG_WRITE) begin
      c = DSR_CMD_MODE_WRITE;
    end
    return c;
  endfunction

  function automatic logic [7:0] modeAddr(input logic [9:0] rise, input logic [9:0] fall);
    return {rise[9:4], fall[1:0]};
  endfunction

  // ==========================================================================
  // reset release
  logic [1:0] rstSync_reg;
  logic rstN;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync_reg <= 2'b00;
    end else begin
      rstSync_reg <= {rstSync_reg[0], 1'b1};
    end
  end

  assign rstN = rstSync_reg[1];

  // ==========================================================================
  // command decode
  dsr_mrr_if mrrBus ();

  dsr_state_type state_reg;
  dsr_state_type state_next;
  dsr_cmd_type cmd;
  logic ckePrev_reg;
  logic [7:0] addr;
  logic enterSr;
  logic mrrStart;
  logic mrwHit;

  assign cmd = decodeCmd(csN, caRise);
  assign addr = modeAddr(caRise, caFall);

  // entry needs clock-gate high the cycle before
  assign enterSr = (cmd == DSR_CMD_SELF_REFRESH) && !cke && ckePrev_reg && !mrrBus.busy;
  // clock-gate held high by controller over the burst
  assign mrrStart = (state_reg == DSR_ST_IDLE) && (cmd == DSR_CMD_MODE_READ) && cke
                    && !mrrBus.busy;
  assign mrwHit = (state_reg == DSR_ST_IDLE) && (cmd == DSR_CMD_MODE_WRITE) && cke
                  && !mrrBus.busy;

  // reserved and read-only addresses fall through unstored
  function automatic logic mwrHitAddr(input logic [7:0] target);
    return mrwHit && (addr == target);
  endfunction

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      ckePrev_reg <= 1'b1;
    end else begin
      ckePrev_reg <= cke;
    end
  end

  // ==========================================================================
  // counters
  logic [1:0] entryCnt_reg;
  logic [15:0] exitCnt_reg;
  logic [15:0] dwellCnt_reg;
  logic [15:0] refCnt_reg;
  logic srActive;

  assign srActive = (state_reg != DSR_ST_IDLE);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      entryCnt_reg <= 2'h0;
    end else if (state_next == DSR_ST_SR_ENTRY && state_reg != DSR_ST_SR_ENTRY) begin
      entryCnt_reg <= 2'h0;
    end else if (state_reg == DSR_ST_SR_ENTRY) begin
      entryCnt_reg <= entryCnt_reg + 2'h1; // two NOP slots
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      exitCnt_reg <= 16'h0000;
    end else if (state_reg == DSR_ST_SR_EXIT) begin
      exitCnt_reg <= exitCnt_reg + 16'h0001;
    end else begin
      exitCnt_reg <= 16'h0000;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      dwellCnt_reg <= 16'h0000;
    end else if (!srActive || (state_reg == DSR_ST_SR_EXIT && enterSr)) begin
      dwellCnt_reg <= 16'h0000;
    end else if (dwellCnt_reg < 16'(SR_MIN_DWELL_CYC)) begin
      dwellCnt_reg <= dwellCnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // state machine
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      DSR_ST_IDLE: begin
        if (enterSr) begin
          state_next = DSR_ST_SR_ENTRY;
        end
      end
      DSR_ST_SR_ENTRY: begin
        if (entryCnt_reg == 2'(POWERDOWN_ENTRY_CYC - 1)) begin
          state_next = DSR_ST_SR;
        end
      end
      DSR_ST_SR: begin
        // only the clock-gate input is heard here
        if (cke) begin
          state_next = DSR_ST_SR_EXIT;
        end
      end
      DSR_ST_SR_EXIT: begin
        if (enterSr) begin
          state_next = DSR_ST_SR_ENTRY;
        end else if (exitCnt_reg == 16'(SR_EXIT_DELAY_CYC - 1)) begin
          state_next = DSR_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= DSR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // internal refresh timer
  logic refreshPulse_reg;
  logic [7:0] refreshBankEn_reg;
  logic [7:0] refreshSegEn_reg;
  logic [7:0] bankMask_reg;
  logic [7:0] segMask_reg;

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      refCnt_reg <= 16'h0000;
    end else if (state_reg == DSR_ST_IDLE) begin
      refCnt_reg <= 16'(SR_FIRST_REFRESH_CYC); // first refresh inside dwell
    end else if (refCnt_reg == 16'h0000) begin
      refCnt_reg <= 16'(SR_REFRESH_INTERVAL_CYC - 1);
    end else begin
      refCnt_reg <= refCnt_reg - 16'h0001;
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      refreshPulse_reg <= 1'b0;
      refreshBankEn_reg <= 8'h00;
      refreshSegEn_reg <= 8'h00;
    end else if (srActive && refCnt_reg == 16'h0000) begin
      refreshPulse_reg <= 1'b1;
      refreshBankEn_reg <= ~bankMask_reg;
      refreshSegEn_reg <= (bankMask_reg == 8'hFF) ? 8'h00 : ~segMask_reg;
    end else begin
      refreshPulse_reg <= 1'b0;
      refreshBankEn_reg <= 8'h00;
      refreshSegEn_reg <= 8'h00;
    end
  end

  // ==========================================================================
  // partial-array mask registers
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      bankMask_reg <= MASK_RESET;
    end else if (mwrHitAddr(MR_ADDR_BANK_MASK)) begin
      bankMask_reg <= caFall[9:2];
    end
  end

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      segMask_reg <= MASK_RESET;
    end else if (mwrHitAddr(MR_ADDR_SEGMENT_MASK)) begin
      segMask_reg <= caFall[9:2];
    end
  end

  // ==========================================================================
  // dropped commands
  logic cmdIgnored_reg;
  logic busyCmd;

  assign busyCmd = (cmd != DSR_CMD_DESELECT) && (cmd != DSR_CMD_NOP);

  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      cmdIgnored_reg <= 1'b0;
    end else if (state_reg == DSR_ST_SR_ENTRY || state_reg == DSR_ST_SR_EXIT) begin
      cmdIgnored_reg <= busyCmd && !enterSr;
    end else if (state_reg == DSR_ST_IDLE && mrrBus.busy) begin
      cmdIgnored_reg <= busyCmd; // only NOP during a burst
    end else if (state_reg == DSR_ST_IDLE) begin
      cmdIgnored_reg <= (cmd == DSR_CMD_MODE_WRITE) && !cke;
    end else begin
      cmdIgnored_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // mode register read
  always_comb begin
    mrrBus.start = mrrStart;
    mrrBus.calMode = (addr == MR_ADDR_CAL_A) || (addr == MR_ADDR_CAL_B);
    mrrBus.calPattern = (addr == MR_ADDR_CAL_B) ? CAL_PATTERN_B : CAL_PATTERN_A;
    if (addr == MR_ADDR_BANK_MASK) begin
      mrrBus.regData = bankMask_reg;
    end else if (addr == MR_ADDR_SEGMENT_MASK) begin
      mrrBus.regData = segMask_reg;
    end else begin
      mrrBus.regData = 8'h00;
    end
  end

  dsr_mrr_burst burstGen (
    .core_clk(core_clk),
    .rstN(rstN),
    .bus(mrrBus)
  );

  // ==========================================================================
  // outputs
  assign dqOut = mrrBus.dq;
  assign dqOe = mrrBus.dqOe;
  assign dqsOut = mrrBus.dqs;
  assign dqsOe = mrrBus.dqsOe;
  assign receiversOn = (state_reg != DSR_ST_SR);
  assign inSelfRefresh = srActive;
  assign refreshPulse = refreshPulse_reg;
  assign refreshBankEn = refreshBankEn_reg;
  assign refreshSegEn = refreshSegEn_reg;
  assign dwellMet = (dwellCnt_reg >= 16'(SR_MIN_DWELL_CYC));
  assign exitBusy = (state_reg == DSR_ST_SR_EXIT);
  assign mrrBusy = mrrBus.busy;
  assign bankMaskOut = bankMask_reg;
  assign segMaskOut = segMask_reg;
  assign cmdIgnored = cmdIgnored_reg;

endmodule
`default_nettype wire

// *** dv/dsr_sr_checker_asserts.sv ***
// checker for the self-refresh, partial-array and mode-read block
// assumes it is bound onto the top module, single core clock
`timescale 1ns/1ps
`default_nettype none
module dsr_sr_checker
  import dsr_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic reset_n, // reset, active low
  input wire logic cke, // clock gate
  input wire logic csN, // chip select, active low
  input wire logic [9:0] caRise, // rise bits
  input wire logic dqOe, // data driven
  input wire logic [3:0] dqsOut, // strobes
  input wire logic dqsOe, // strobes driven
  input wire logic receiversOn, // receivers on
  input wire logic inSelfRefresh, // self refresh
  input wire logic refreshPulse, // refresh event
  input wire logic [7:0] refreshBankEn, // banks refreshed
  input wire logic [7:0] refreshSegEn, // segments refreshed
  input wire logic exitBusy, // exit delay
  input wire logic mrrBusy, // read burst
  input wire logic [7:0] bankMaskOut, // bank mask
  input wire logic [7:0] segMaskOut, // segment mask
  input wire logic cmdIgnored // dropped command
);
  localparam int DwellMax = SR_MIN_DWELL_CYC;
  logic [1:0] liveCnt_reg;
  logic [5:0] exitCnt_reg;
  logic live;
  // ==========
  // helper counters
  assign live = (liveCnt_reg == 2'h3);
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) liveCnt_reg <= 2'h0;
    else if (!live) liveCnt_reg <= liveCnt_reg + 2'h1;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) exitCnt_reg <= 6'h00;
    else exitCnt_reg <= exitBusy ? exitCnt_reg + 6'h01 : 6'h00;
  end
  // ==========
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sre_entry_a: assert property (live && !csN && !cke && $past(cke)
    && caRise[2:0] == CA_SELF_REFRESH && !mrrBusy && (!inSelfRefresh || exitBusy)
    |=> inSelfRefresh) else $error("self refresh entry not taken");
  receivers_off_a: assert property ($rose(inSelfRefresh) |-> ##2 !receiversOn)
    else $error("receivers still on after entry delay");
  stay_asleep_a: assert property (!receiversOn && !cke |=> !receiversOn && inSelfRefresh)
    else $error("left self refresh with clock gate low");
  first_refresh_a: assert property ($rose(inSelfRefresh) |-> ##[0:DwellMax] refreshPulse)
    else $error("no refresh within dwell");
  bank_mask_a: assert property (refreshPulse |-> refreshBankEn == ~bankMaskOut)
    else $error("bank enables wrong");
  seg_mask_a: assert property (refreshPulse |-> refreshSegEn ==
    ((bankMaskOut == 8'hFF) ? 8'h00 : ~segMaskOut)) else $error("segment enables wrong");
  mrr_burst_a: assert property (live && !csN && cke && caRise[3:0] == CA_MODE_REG_READ
    && !mrrBusy && !inSelfRefresh |=> !dqOe [*8] ##1 !dqOe ##1 dqOe [*8] ##1 !dqOe)
    else $error("read burst timing wrong");
  strobe_toggle_a: assert property (dqOe |-> dqsOe &&
    dqsOut == ($past(dqOe) ? ~$past(dqsOut) : 4'hF)) else $error("strobes not toggling");
  burst_refuse_a: assert property (live && mrrBusy && !csN && caRise[2:0] != CA_NOP
    |=> cmdIgnored) else $error("command during burst not dropped");
  wake_up_a: assert property (!receiversOn && cke |=> exitBusy && receiversOn)
    else $error("exit not started");
  exit_len_a: assert property ($fell(exitBusy) |->
    exitCnt_reg == 6'(SR_EXIT_DELAY_CYC) && !inSelfRefresh) else $error("exit delay wrong");
  mask_freeze_a: assert property (inSelfRefresh |=> $stable(bankMaskOut) && $stable(segMaskOut))
    else $error("mask changed in self refresh");
endmodule
bind dsr_self_refresh_pasr_mrr dsr_sr_checker dsr_sr_checker_i (
  .core_clk(core_clk),
  .reset_n(reset_n),
  .cke(cke),
  .csN(csN),
  .caRise(caRise),
  .dqOe(dqOe),
  .dqsOut(dqsOut),
  .dqsOe(dqsOe),
  .receiversOn(receiversOn),
  .inSelfRefresh(inSelfRefresh),
  .refreshPulse(refreshPulse),
  .refreshBankEn(refreshBankEn),
  .refreshSegEn(refreshSegEn),
  .exitBusy(exitBusy),
  .mrrBusy(mrrBusy),
  .bankMaskOut(bankMaskOut),
  .segMaskOut(segMaskOut),
  .cmdIgnored(cmdIgnored)
);
`default_nettype wire

// *** dv/dsr_ctrl_model.sv ***
// memory controller model driving clock gate, chip select and command pins
// assumes one caller process and a clock that keeps running
`timescale 1ns/1ps
`default_nettype none
module dsr_ctrl_model
  import dsr_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic mrrBusy, // device read burst busy
  output logic cke, // clock gate
  output logic csN, // chip select, active low
  output logic [9:0] caRise, // rise bits
  output logic [9:0] caFall // fall bits
);
  initial begin
    cke = 1'b1;
    csN = 1'b1;
    caRise = 10'h000;
    caFall = 10'h000;
  end
  // ==========
  // pin drivers, all changes at the falling edge
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge core_clk);
      csN = 1'b1;
      caRise = ~caRise;
      caFall = ~caFall;
    end
  endtask
  task automatic send(input logic [3:0] op, input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    csN = 1'b0;
    caRise = {a[7:2], op};
    caFall = {d, a[1:0]};
  endtask
  task automatic nop(input int n);
    repeat (n) send({1'b0, CA_NOP}, 8'h00, 8'h00);
  endtask
  task automatic enter_sr;
    while (mrrBusy !== 1'b0) nop(1);
    send({1'b0, CA_SELF_REFRESH}, 8'h00, 8'h00);
    cke = 1'b0;
    nop(POWERDOWN_ENTRY_CYC);
    idle(2);
  endtask
  task automatic exit_sr(input int dwell);
    idle(dwell);
    nop(1);
    cke = 1'b1;
    nop(SR_EXIT_DELAY_CYC + 2);
  endtask
  task automatic refresh_all;
    send(4'hC, 8'h00, 8'h00);
    nop(1);
  endtask
endmodule
`default_nettype wire

// *** dv/dsr_self_refresh_pasr_mrr_tb_top.sv ***
// self-checking bench: random mask writes, mode reads, self-refresh rounds
// assumes the controller model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module dsr_self_refresh_pasr_mrr_tb_top;
  import dsr_pkg::*;
  logic core_clk, reset_n, cke, csN, dqOe, dqsOe, receiversOn, inSelfRefresh;
  logic refreshPulse, dwellMet, exitBusy, mrrBusy, cmdIgnored;
  logic [9:0] caRise, caFall;
  logic [31:0] dqOut;
  logic [3:0] dqsOut;
  logic [7:0] refreshBankEn, refreshSegEn, bankMaskOut, segMaskOut, rBank, rSeg, bank, seg;
  logic [31:0] beats [8];
  int fails = 0;
  int n_tests = 0;
  int cycles = 0;
  int pulses = 0;
  int ign = 0;
  int p0, i0;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  dsr_self_refresh_pasr_mrr dsr_self_refresh_pasr_mrr_i (.core_clk(core_clk),
    .reset_n(reset_n), .cke(cke), .csN(csN), .caRise(caRise), .caFall(caFall),
    .dqOut(dqOut), .dqOe(dqOe), .dqsOut(dqsOut), .dqsOe(dqsOe), .receiversOn(receiversOn),
    .inSelfRefresh(inSelfRefresh), .refreshPulse(refreshPulse), .refreshBankEn(refreshBankEn),
    .refreshSegEn(refreshSegEn), .dwellMet(dwellMet), .exitBusy(exitBusy), .mrrBusy(mrrBusy),
    .bankMaskOut(bankMaskOut), .segMaskOut(segMaskOut), .cmdIgnored(cmdIgnored));
  dsr_ctrl_model ctrl_i (.core_clk(core_clk), .mrrBusy(mrrBusy), .cke(cke), .csN(csN),
    .caRise(caRise), .caFall(caFall));
  // ==========
  // monitors and timeout
  always @(negedge core_clk) begin
    cycles++;
    if (refreshPulse === 1'b1) begin
      pulses++;
      rBank = refreshBankEn;
      rSeg = refreshSegEn;
    end
    if (cmdIgnored === 1'b1) ign++;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end
  // ==========
  // helpers
  function automatic logic [31:0] exp_beat(input logic [7:0] a, input int b);
    if (a == MR_ADDR_CAL_A) return {32{CAL_PATTERN_A[b]}};
    if (a == MR_ADDR_CAL_B) return {32{CAL_PATTERN_B[b]}};
    if (b != 0) return 32'h0;
    if (a == MR_ADDR_BANK_MASK) return {24'h0, bank};
    if (a == MR_ADDR_SEGMENT_MASK) return {24'h0, seg};
    return 32'h0;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic mode_write(input logic [7:0] a, input logic [7:0] d);
    ctrl_i.send(CA_MODE_REG_WRITE, a, d);
    ctrl_i.nop(2);
    if (a == MR_ADDR_BANK_MASK) bank = d;
    if (a == MR_ADDR_SEGMENT_MASK) seg = d;
    check({16'h0, bankMaskOut, segMaskOut}, {16'h0, bank, seg}, "masks");
  endtask
  task automatic mode_read(input logic [7:0] a, input bit intrude);
    int k;
    k = 0;
    ctrl_i.send(CA_MODE_REG_READ, a, 8'h00);
    for (int n = 0; n < 24; n++) begin
      if (intrude && n == 3) ctrl_i.send(CA_MODE_REG_WRITE, MR_ADDR_BANK_MASK, ~bank);
      else ctrl_i.nop(1);
      if (dqOe === 1'b1 && k < 8) begin
        beats[k] = dqOut;
        k++;
      end
    end
    while (mrrBusy !== 1'b0) ctrl_i.nop(1);
    check(32'(k), 32'd8, "beat count");
    for (int b = 0; b < 8; b++) check(beats[b], exp_beat(a, b), "read beat");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ==========
  // main sequence
  initial begin
    reset_n = 1'b0;
    bank = MASK_RESET;
    seg = MASK_RESET;
    p0 = $urandom(26809);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk) reset_n = 1'b1;
    ctrl_i.idle(4);
    check({7'h0, dwellMet, receiversOn, inSelfRefresh, dqOe, dqsOe, mrrBusy,
      exitBusy, refreshPulse, cmdIgnored, bankMaskOut, segMaskOut},
      {16'h0080, MASK_RESET, MASK_RESET}, "reset");
    $display("test reset done");
    for (int r = 0; r < 4; r++) begin
      mode_write(MR_ADDR_BANK_MASK, 8'($urandom));
      mode_write(MR_ADDR_SEGMENT_MASK, 8'($urandom));
      mode_write(MR_ADDR_PASR_RESERVED, 8'($urandom));
      mode_read(MR_ADDR_BANK_MASK, 1'b0);
      mode_read(MR_ADDR_SEGMENT_MASK, 1'b0);
      mode_read(MR_ADDR_PASR_RESERVED, 1'b0);
      ctrl_i.idle($urandom_range(1, 5));
    end
    $display("test mask write and read done");
    mode_read(MR_ADDR_CAL_A, 1'b0);
    mode_read(MR_ADDR_CAL_B, 1'b0);
    i0 = ign;
    mode_read(MR_ADDR_BANK_MASK, 1'b1);
    check(32'(ign - i0), 32'd1, "dropped count");
    check({24'h0, bankMaskOut}, {24'h0, bank}, "mask kept");
    $display("test calibration and burst refusal done");
    for (int r = 0; r < 2; r++) begin
      if (r == 1) mode_write(MR_ADDR_BANK_MASK, 8'hFF);
      p0 = pulses;
      ctrl_i.enter_sr();
      check({29'h0, dwellMet, receiversOn, inSelfRefresh}, 32'h5, "asleep");
      ctrl_i.send(CA_MODE_REG_WRITE, MR_ADDR_SEGMENT_MASK, ~seg);
      ctrl_i.exit_sr(SR_REFRESH_INTERVAL_CYC + 20);
      check(32'(pulses - p0 >= 2), 32'd1, "timer refreshes");
      check({24'h0, rBank}, {24'h0, ~bank}, "bank enables");
      check({24'h0, rSeg}, {24'h0, (bank == 8'hFF) ? 8'h00 : ~seg}, "seg enables");
      check({13'h0, dwellMet, receiversOn, inSelfRefresh,
        bankMaskOut, segMaskOut}, {13'h0, 3'b010, bank, seg}, "after exit");
      ctrl_i.refresh_all();
      ctrl_i.idle($urandom_range(1, 5));
    end
    $display("test self refresh done");
    complete_run();
  end
endmodule
`default_nettype wire
